// ---- pri_ctrl.sv ----
/*
  Priority interrupt controller with APB register access and a core request port.
  Assumes one clock, core_ack pulses only while irq_req is high, and core_return
  pulses once per handler exit.
*/
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "pri_consts.svh"
module pri_ctrl #(
  parameter int STACK_DEPTH = 8,
  parameter int DISABLE_W = 16
) (
  input wire logic pclk,           // APB clock, 250 MHz
  input wire logic presetn,        // Async reset, active low
  input wire logic pce,            // Clock enable, freezes state when low
  input wire logic psel,           // APB select
  input wire logic penable,        // APB enable
  input wire logic pwrite,         // APB direction
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready
  output logic pslverr,            // APB error, unmapped address
  input wire logic [4:0] src_event, // User source event pulses
  input wire logic [7:0] trap_event, // Trap event pulses, levels 8 to 15
  input wire logic core_ack,       // Core accepts the request
  input wire logic core_return,    // Core returns from a handler
  output logic irq_req,            // Request to the core
  output pri_pkg::pri_vec_t irq_vector, // Requested vector id
  output pri_pkg::pri_level_t irq_level // Requested level
);
  localparam int NU = 5;
  localparam int NT = 8;
  localparam int NS = NT + NU;

  typedef struct packed {
    logic [NU-1:0][2:0] prio;
    logic [NU-1:0] flag;
    logic [NU-1:0] en;
    logic [NT-1:0] trap;
    logic nest_dis;
    logic vector_capture_select;
    logic [3:0] level;
    logic [6:0] last_vec;
    logic [DISABLE_W-1:0] disable_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_req;
    logic [6:0] irq_vec;
    logic [3:0] irq_lvl;
  } pri_state_s;

  pri_state_s s_q;
  pri_state_s s_d;

  // ==========================================================
  // Request levels per source
  logic [NS-1:0][3:0] pend_lvl;
  logic [NS-1:0][3:0] elig_lvl;
  pri_pkg::pri_level_t pend_best_lvl;
  pri_pkg::pri_vec_t pend_best_idx;
  pri_pkg::pri_level_t elig_best_lvl;
  pri_pkg::pri_vec_t elig_best_idx;
  pri_pkg::pri_level_t stack_top;
  logic nested;
  logic accept;
  logic stack_pop;

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      // Trap levels are fixed; a trap is masked only by a core level at or above its own
      pend_lvl[t] = s_q.trap[t] ? 4'(`PRI_LVL_TRAP_BASE + 4'(t)) : `PRI_LVL_NONE;
      elig_lvl[t] = (pend_lvl[t] > s_q.level) ? pend_lvl[t] : `PRI_LVL_NONE;
    end
    for (int u = 0; u < NU; u++) begin
      pend_lvl[NT + u] = `PRI_LVL_NONE;
      if (s_q.flag[u] && s_q.en[u] && s_q.prio[u] != 3'h0) begin
        pend_lvl[NT + u] = {1'b0, s_q.prio[u]};
      end
      elig_lvl[NT + u] = pend_lvl[NT + u];
      // Core level 7 is at or above any user level, so all users are held
      if (pend_lvl[NT + u] <= s_q.level) begin
        elig_lvl[NT + u] = `PRI_LVL_NONE;
      end
      if (s_q.disable_cnt != '0 && pend_lvl[NT + u] < `PRI_LVL_USER_TOP) begin
        elig_lvl[NT + u] = `PRI_LVL_NONE;
      end
      // Traps still preempt; only user sources are held while nested
      if (s_q.nest_dis && nested) begin
        elig_lvl[NT + u] = `PRI_LVL_NONE;
      end
    end
  end

  pri_arbiter #(
    .N(NS)
  ) u_pend_arb (
    .lvl(pend_lvl),
    .best_lvl(pend_best_lvl),
    .best_idx(pend_best_idx)
  );

  pri_arbiter #(
    .N(NS)
  ) u_elig_arb (
    .lvl(elig_lvl),
    .best_lvl(elig_best_lvl),
    .best_idx(elig_best_idx)
  );

  // ==========================================================
  // Saved level stack
  assign accept = core_ack && s_q.irq_req;
  assign stack_pop = core_return && !accept;

  pri_level_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .push(accept),
    .pop(stack_pop),
    .push_data(s_q.level),
    .top(stack_top),
    .nested(nested)
  );

  // ==========================================================
  // Register read view
  logic unacked;
  pri_pkg::pri_vec_t shown_vec;
  logic [31:0] rd_word;
  logic mapped;
  logic setup;
  logic wr;

  assign unacked = (pend_best_lvl != `PRI_LVL_NONE) && (pend_best_lvl <= s_q.level);
  assign shown_vec = s_q.vector_capture_select ? pend_best_idx : s_q.last_vec;
  assign setup = psel && !penable;
  assign wr = psel && penable && s_q.pready && pwrite;

  always_comb begin
    rd_word = '0; // Unimplemented bits read as zero
    mapped = 1'b1;
    unique case (paddr)
      `PRI_OFF_ERR_PRIO: begin
        rd_word[`PRI_CSUM_LSB +: 3] = s_q.prio[0];
        rd_word[`PRI_SER2_LSB +: 3] = s_q.prio[1];
        rd_word[`PRI_SER1_LSB +: 3] = s_q.prio[2];
      end
      `PRI_OFF_LVD_PRIO: rd_word[`PRI_LVD_LSB +: 3] = s_q.prio[3];
      `PRI_OFF_CTM_PRIO: rd_word[`PRI_CTM_LSB +: 3] = s_q.prio[4];
      `PRI_OFF_STATE: begin
        rd_word[`PRI_PEND_BIT] = unacked;
        rd_word[`PRI_VECTOR_CAPTURE_SELECT_BIT] = s_q.vector_capture_select;
        rd_word[`PRI_ILR_LSB +: 4] = s_q.level;
        rd_word[6:0] = shown_vec;
      end
      `PRI_OFF_FLAGS: rd_word[NU-1:0] = s_q.flag;
      `PRI_OFF_ENABLES: rd_word[NU-1:0] = s_q.en;
      `PRI_OFF_CONTROL: begin
        rd_word[`PRI_NEST_BIT] = s_q.nest_dis;
        rd_word[NT-1:0] = s_q.trap;
      end
      `PRI_OFF_CORE_LVL: rd_word[3:0] = s_q.level;
      `PRI_OFF_DISABLE: rd_word[DISABLE_W-1:0] = s_q.disable_cnt;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // APB: answer loaded in setup, so access completes on its first edge
    s_d.pready = setup;
    s_d.pslverr = setup && !mapped;
    s_d.prdata = (setup && !pwrite) ? rd_word : '0;

    if (wr) begin
      unique case (paddr)
        `PRI_OFF_ERR_PRIO: begin
          s_d.prio[0] = pwdata[`PRI_CSUM_LSB +: 3];
          s_d.prio[1] = pwdata[`PRI_SER2_LSB +: 3];
          s_d.prio[2] = pwdata[`PRI_SER1_LSB +: 3];
        end
        `PRI_OFF_LVD_PRIO: s_d.prio[3] = pwdata[`PRI_LVD_LSB +: 3];
        `PRI_OFF_CTM_PRIO: s_d.prio[4] = pwdata[`PRI_CTM_LSB +: 3];
        `PRI_OFF_STATE: s_d.vector_capture_select = pwdata[`PRI_VECTOR_CAPTURE_SELECT_BIT];
        `PRI_OFF_FLAGS: s_d.flag = pwdata[NU-1:0];
        `PRI_OFF_ENABLES: s_d.en = pwdata[NU-1:0];
        `PRI_OFF_CONTROL: begin
          s_d.nest_dis = pwdata[`PRI_NEST_BIT];
          s_d.trap = s_q.trap & ~pwdata[NT-1:0]; // Software clears traps
        end
        `PRI_OFF_CORE_LVL: s_d.level = {1'b0, pwdata[2:0]};
        `PRI_OFF_DISABLE: s_d.disable_cnt = pwdata[DISABLE_W-1:0];
        default: ;
      endcase
    end

    // Timed disable runs down once per enabled cycle
    if (!(wr && paddr == `PRI_OFF_DISABLE) && s_q.disable_cnt != '0) begin
      s_d.disable_cnt = DISABLE_W'(s_q.disable_cnt - 1'b1);
    end

    // Events win over a clear in the same cycle
    s_d.flag = s_d.flag | src_event;
    s_d.trap = s_d.trap | trap_event;

    // Core handshake: accept raises the level, return restores it
    if (accept) begin
      s_d.level = s_q.irq_lvl;
      s_d.last_vec = s_q.irq_vec;
    end else if (core_return) begin
      s_d.level = stack_top;
    end

    // Drop the request for the cycle after accept or return while the level settles;
    // a flag still set after return requests again here
    s_d.irq_req = (elig_best_lvl != `PRI_LVL_NONE) && !accept && !core_return;
    s_d.irq_vec = elig_best_idx;
    s_d.irq_lvl = elig_best_lvl;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.prio <= {NU{`PRI_PRIO_RST}};
    end else if (pce) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq_req = s_q.irq_req;
  assign irq_vector = s_q.irq_vec;
  assign irq_level = s_q.irq_lvl;
endmodule

// ---- pri_consts.svh ----
/*
  Constants for the priority interrupt controller: register offsets, field positions,
  reset values and level figures. Assumes inclusion by pri_ctrl and its leaf modules.
*/
// What this block does
// - Each user source has a 3-bit priority, 111 is level 7, 001 is level 1.
// - Priority code 000 disables a source; it never requests.
// - Error priorities: checksum at 14-12, serial2 at 10-8, serial1 at 6-4.
// - Low-voltage priority at bits 2-0; other bits unimplemented.
// - Charge-measure priority at bits 6-4; other bits unimplemented.
// - Unimplemented bits ignore writes and read as zero.
// - Reset sets every user priority field to level 4.
// - Status bit 15 shows a request held back by equal or higher core priority.
// - Capture select 1: vector field shows highest-priority pending source.
// - Capture select 0: vector field holds last source accepted by core.
// - Status bits 11-8 show core priority level, 0 to 15.
// - Status bits 6-0 give vector id; vector number is id plus 8.
// - A flag left set at handler return requests again at once.
// - Return restores the previous core priority level.
// - Core level 7 blocks every user source.
// - Traps at levels 8-15 are masked only by a core level at or above their own.
// - Timed disable blocks levels 1-6 for a set time; level 7 passes.
// - Nesting disable stops any user source preempting a running handler; traps still preempt.
// - A user source requests only with flag and enable both set.
`ifndef PRI_CONSTS_SVH
`define PRI_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define PRI_OFF_ERR_PRIO   8'h00
`define PRI_OFF_LVD_PRIO   8'h04
`define PRI_OFF_CTM_PRIO   8'h08
`define PRI_OFF_STATE      8'h0C
`define PRI_OFF_FLAGS      8'h10
`define PRI_OFF_ENABLES    8'h14
`define PRI_OFF_CONTROL    8'h18
`define PRI_OFF_CORE_LVL   8'h1C
`define PRI_OFF_DISABLE    8'h20

// ==========================================================
// Field positions
`define PRI_CSUM_LSB       12
`define PRI_SER2_LSB       8
`define PRI_SER1_LSB       4
`define PRI_LVD_LSB        0
`define PRI_CTM_LSB        4
`define PRI_PEND_BIT       15
`define PRI_VECTOR_CAPTURE_SELECT_BIT      13
`define PRI_ILR_LSB        8
`define PRI_NEST_BIT       15

// ==========================================================
// Values and levels
`define PRI_PRIO_RST       3'h4
`define PRI_LVL_NONE       4'h0
`define PRI_LVL_USER_TOP   4'h7
`define PRI_LVL_TRAP_BASE  4'h8
`define PRI_USER_ID_BASE   7'h08

`endif

// ---- pri_pkg.sv ----
/*
  Types shared by the priority interrupt controller modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pri_pkg;
  typedef logic [3:0] pri_level_t;
  typedef logic [6:0] pri_vec_t;
endpackage

// ---- pri_arbiter.sv ----
/*
  Priority arbiter: picks the highest non-zero level, lowest index on ties.
  Assumes lvl is already zero for sources that are not requesting.
*/
`timescale 1ns/10ps
`include "pri_consts.svh"
module pri_arbiter #(
  parameter int N = 13
) (
  input wire logic [N-1:0][3:0] lvl,     // Level per source, zero if idle
  output pri_pkg::pri_level_t best_lvl, // Winning level
  output pri_pkg::pri_vec_t best_idx    // Winning source index
);
  always_comb begin
    best_lvl = `PRI_LVL_NONE;
    best_idx = '0;
    // Walk downward so an equal level at a lower index overrides
    for (int i = N - 1; i >= 0; i--) begin
      if (lvl[i] != `PRI_LVL_NONE && lvl[i] >= best_lvl) begin
        best_lvl = lvl[i];
        best_idx = 7'(i);
      end
    end
  end
endmodule

// ---- pri_level_stack.sv ----
/*
  Stack of previous core priority levels, pushed on accept, popped on return.
  Assumes push and pop never come in the same cycle.
*/
`timescale 1ns/10ps
`include "pri_consts.svh"
module pri_level_stack #(
  parameter int DEPTH = 8
) (
  input wire logic pclk,                  // Clock
  input wire logic presetn,               // Async reset, active low
  input wire logic pce,                   // Clock enable
  input wire logic push,                  // Save a level
  input wire logic pop,                   // Restore a level
  input wire pri_pkg::pri_level_t push_data, // Level to save
  output pri_pkg::pri_level_t top,        // Most recent saved level
  output logic nested                     // At least one level saved
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][3:0] mem;
    logic [CW-1:0] cnt;
  } pri_stack_s;

  pri_stack_s s_q;
  pri_stack_s s_d;

  always_comb begin
    s_d = s_q;
    // Overflowing pushes are dropped; depth must cover the deepest nesting
    if (push && s_q.cnt != CW'(DEPTH)) begin
      s_d.mem[IW'(s_q.cnt)] = push_data;
      s_d.cnt = CW'(s_q.cnt + 1'b1);
    end else if (pop && s_q.cnt != '0) begin
      s_d.cnt = CW'(s_q.cnt - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (pce) begin
      s_q <= s_d;
    end
  end

  assign top = (s_q.cnt != '0) ? s_q.mem[IW'(s_q.cnt - 1'b1)] : `PRI_LVL_NONE;
  assign nested = (s_q.cnt != '0);
endmodule

// ---- pri_ctrl_checker.sv ----
/*
  Port checker for pri_ctrl, bound to every instance.
  Assumes pce is held high, so each setup cycle is answered at once.
*/
`timescale 1ns/10ps
// ==========================================================
// Checker
module pri_ctrl_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic core_ack, // Core accept
  input wire logic irq_req, // Request to core
  input wire pri_pkg::pri_vec_t irq_vector, // Vector id
  input wire pri_pkg::pri_level_t irq_level // Request level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property ($rose(pready) |-> $past(psel) && !$past(penable) ##1 !pready)
    else $error("ready not a single setup answer");
  AST_BAD_ADDR: assert property (psel && !penable && paddr > 8'h20 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_ERR_PRIO_BITS: assert property (rd_ok && paddr == 8'h00 |-> (prdata & 32'hFFFF8888) == 0)
    else $error("error priority spare bits set");
  AST_LVD_BITS: assert property (rd_ok && paddr == 8'h04 |-> (prdata & 32'hFFFFFFF8) == 0)
    else $error("low voltage spare bits set");
  AST_CTM_BITS: assert property (rd_ok && paddr == 8'h08 |-> (prdata & 32'hFFFFFF8F) == 0)
    else $error("charge measure spare bits set");
  AST_STATE_BITS: assert property (rd_ok && paddr == 8'h0C |-> (prdata & 32'hFFFF5080) == 0)
    else $error("state spare bits set");
  AST_REQ_LEVEL: assert property (irq_req |-> irq_level != 4'h0)
    else $error("request at level zero");
  AST_TRAP_VEC: assert property (irq_req && irq_level[3] |-> irq_vector == {4'h0, irq_level[2:0]})
    else $error("trap vector does not match level");
  AST_USER_VEC: assert property (irq_req && !irq_level[3] |-> irq_vector inside {[7'h08:7'h0C]})
    else $error("user vector out of range");
  AST_ACK_DROP: assert property (core_ack && irq_req |=> !irq_req)
    else $error("request kept after accept");
endmodule

bind pri_ctrl pri_ctrl_checker pri_ctrl_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_ack(core_ack), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_level(irq_level));

// ---- pri_core_model.sv ----
/*
  Processor core model on the request port: accepts after ack_wait cycles, runs
  each handler for run_len cycles, nests as deep as the controller lets it.
  Assumes the bench holds its settings steady while a handler runs.
*/
`timescale 1ns/10ps
module pri_core_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic enable, // Accept requests when high
  input wire logic [3:0] ack_wait, // Request cycles before accepting
  input wire logic [7:0] run_len, // Handler length in cycles
  input wire logic irq_req, // Request from controller
  output logic core_ack, // Accept pulse
  output logic core_return // Handler exit pulse
);
  logic [3:0] wait_q;
  logic [7:0] run_q;
  logic [3:0] depth_q;
  logic take;
  // Never accept two cycles running, so one request gives one accept
  assign take = enable && irq_req && !core_ack && wait_q >= ack_wait;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      run_q <= 8'h00;
      depth_q <= 4'h0;
      core_ack <= 1'b0;
      core_return <= 1'b0;
    end else begin
      core_ack <= take;
      core_return <= 1'b0;
      wait_q <= (irq_req && !take && wait_q != 4'hF) ? wait_q + 4'h1 : (take ? 4'h0 : wait_q);
      if (!irq_req) begin
        wait_q <= 4'h0;
      end
      if (take) begin
        depth_q <= depth_q + 4'h1;
        run_q <= 8'h00;
      end else if (depth_q != 4'h0 && run_q == run_len) begin
        core_return <= 1'b1;
        depth_q <= depth_q - 4'h1;
        run_q <= 8'h00;
      end else if (depth_q != 4'h0) begin
        run_q <= run_q + 8'h01;
      end
    end
  end
endmodule

// ---- testbench.sv ----
/*
  Self-checking bench for pri_ctrl with a core model on the request port.
  Assumes the register map and zero-wait APB timing of pri_ctrl; pce stays high.
*/
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic core_en = 1'b0, pready, pslverr, core_ack, core_return, irq_req, e;
  logic [7:0] paddr = 8'h00, trap_event = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [4:0] src_event = 5'h00;
  pri_pkg::pri_vec_t irq_vector;
  pri_pkg::pri_level_t irq_level;
  int num_errors = 0, total_checks = 0;
  always #2 pclk = ~pclk;
  pri_ctrl #(.STACK_DEPTH(4)) pri_ctrl_inst (.pclk(pclk), .presetn(presetn), .pce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
    .trap_event(trap_event), .core_ack(core_ack), .core_return(core_return),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level));
  pri_core_model pri_core_model_inst (.pclk(pclk), .presetn(presetn), .enable(core_en),
    .ack_wait(4'h2), .run_len(8'h28), .irq_req(irq_req), .core_ack(core_ack),
    .core_return(core_return));
  // ==========================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      report_and_stop;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic ev(input logic [4:0] s, input logic [7:0] t);
    @(posedge pclk);
    src_event <= s;
    trap_event <= t;
    @(posedge pclk);
    src_event <= 5'h00;
    trap_event <= 8'h00;
  endtask
  // Kind 0 waits for a request, 1 for an accept, 2 for a return
  task automatic wait_on(input int k);
    repeat (200) begin
      @(posedge pclk);
      if (k == 0 ? irq_req === 1'b1 : (k == 1 ? core_ack === 1'b1 : core_return === 1'b1)) return;
    end
    num_errors++;
    report_and_stop;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(8'h00, 32'h4440);
    rd(8'h04, 32'h4);
    rd(8'h08, 32'h40);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h7770);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h7);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h70);
    rd(8'hFC, 32'h0);
    chk(e, 1'b1);
  endtask
  task automatic t_gate;
    wr(8'h00, 32'h0770);
    wr(8'h14, 32'h1F);
    ev(5'h01, 8'h00);
    repeat (8) @(posedge pclk);
    chk(irq_req, 1'b0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h7770);
    repeat (4) @(posedge pclk);
    chk(irq_req, 1'b0);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_tie;
    wr(8'h00, 32'h4440);
    wr(8'h14, 32'h1F);
    ev(5'h06, 8'h00);
    wait_on(0);
    chk(irq_vector, 7'h09);
    chk(irq_level, 4'h4);
    wr(8'h00, 32'h4450);
    repeat (3) @(posedge pclk);
    chk(irq_vector, 7'h0A);
    chk(irq_level, 4'h5);
    wr(8'h0C, 32'h2000);
    rd(8'h0C, 32'h200A);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_mask;
    ev(5'h01, 8'h00);
    wr(8'h1C, 32'h7);
    repeat (3) @(posedge pclk);
    chk(irq_req, 1'b0);
    rd(8'h0C, 32'hA708);
    ev(5'h00, 8'h04);
    wait_on(0);
    chk(irq_vector, 7'h02);
    chk(irq_level, 4'hA);
    wr(8'h18, 32'h4);
    repeat (3) @(posedge pclk);
    chk(irq_req, 1'b0);
    wr(8'h1C, 32'h0);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_handler;
    wr(8'h0C, 32'h0);
    core_en <= 1'b1;
    ev(5'h10, 8'h00);
    wait_on(1);
    chk(irq_vector, 7'h0C);
    wait_on(2);
    wait_on(1);
    rd(8'h0C, 32'h870C);
    wr(8'h10, 32'h0);
    wait_on(2);
    repeat (6) @(posedge pclk);
    chk(irq_req, 1'b0);
    rd(8'h0C, 32'h000C);
    core_en <= 1'b0;
  endtask
  task automatic t_timed_interrupt_disable;
    wr(8'h00, 32'h6440);
    wr(8'h20, 32'h64);
    // Loaded at the write edge, then one step down per cycle to the read setup edge
    rd(8'h20, 32'h63);
    ev(5'h01, 8'h00);
    repeat (8) @(posedge pclk);
    chk(irq_req, 1'b0);
    wr(8'h00, 32'h7440);
    wait_on(0);
    chk(irq_vector, 7'h08);
    wr(8'h10, 32'h0);
    repeat (100) @(posedge pclk);
  endtask
  task automatic t_nest;
    wr(8'h18, 32'h8000);
    core_en <= 1'b1;
    ev(5'h02, 8'h00);
    wait_on(1);
    chk(irq_vector, 7'h09);
    ev(5'h01, 8'h00);
    repeat (10) @(posedge pclk);
    chk(irq_req, 1'b0);
    wait_on(2);
    wait_on(1);
    chk(irq_vector, 7'h08);
    wr(8'h10, 32'h0);
    core_en <= 1'b0;
  endtask
  // Mid-run reset must bring priorities and status back to their reset values
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h4440);
    rd(8'h0C, 32'h0);
    chk(irq_req, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_gate;
    t_tie;
    t_mask;
    t_handler;
    t_timed_interrupt_disable;
    t_nest;
    t_reset;
    report_and_stop;
  end
endmodule
